// ==== rtl/plmc_cfg.svh ====
/*
 * Offsets, field positions, reset values and limits of the LED, crossover and pause register group.
 * Assumes it is included by bare name into files that also see plmc_pkg.
 */
`ifndef PLMC_CFG_SVH
`define PLMC_CFG_SVH

// Register indexes; the APB byte address is four times the index.
`define PLMC_IDX_RX_BUF      6'h17
`define PLMC_IDX_LED_CTL     6'h18
`define PLMC_IDX_PHY_CTL     6'h19

// Receive buffer configuration fields.
`define PLMC_RXB_TOL_LSB     0
`define PLMC_RXB_WIDE_BIT    8
`define PLMC_RXB_TOL_RST     2'h1

// LED direct-control fields.
`define PLMC_LED_FORCE_BIT   1
`define PLMC_LED_OVR_BIT     4

// PHY control fields.
`define PLMC_PHY_AUTOX_BIT   15
`define PLMC_PHY_FORCEX_BIT  14
`define PLMC_PHY_PRX_BIT     13
`define PLMC_PHY_PTX_BIT     12
`define PLMC_PHY_INJ_BIT     11

// Advertisement and partner ability pause field.
`define PLMC_ADV_PAUSE_LSB   10

// Tolerance in bits for each code.
`define PLMC_TOL_BITS_00     4'hE
`define PLMC_TOL_BITS_01     4'h2
`define PLMC_TOL_BITS_10     4'h6
`define PLMC_TOL_BITS_11     4'hA

// Longest packet in bytes for each code at the narrow clock accuracy.
`define PLMC_PKT_BYTES_00    15'h41A0
`define PLMC_PKT_BYTES_01    15'h0960
`define PLMC_PKT_BYTES_10    15'h1C20
`define PLMC_PKT_BYTES_11    15'h2EE0

`endif

// ==== rtl/plmc_pkg.sv ====
/*
 * Types shared by the register group and its pause resolver.
 * Assumes nothing of its surroundings.
 */
package plmc_pkg;

    // Receive elasticity tolerance codes.
    typedef enum logic [1:0] {
        PLMC_TOL_14 = 2'h0,
        PLMC_TOL_2  = 2'h1,
        PLMC_TOL_6  = 2'h2,
        PLMC_TOL_10 = 2'h3
    } plmc_tol_t;

    // Pause capability pair: asymmetric direction above symmetric pause.
    typedef struct packed {
        logic asymDir;
        logic symPause;
    } plmc_pause_caps_t;

endpackage

// ==== rtl/plmc_pause_if.sv ====
/*
 * Carrier between the register group and its pause resolver.
 * Assumes both ends run on the same clock; the resolver is combinational.
 */
`timescale 1ns/1ps
interface plmc_pause_if;
    plmc_pkg::plmc_pause_caps_t localCaps;
    plmc_pkg::plmc_pause_caps_t partnerCaps;
    logic                       rxEnable;
    logic                       txEnable;

    modport resolver (input localCaps, input partnerCaps, output rxEnable, output txEnable);
    modport user     (output localCaps, output partnerCaps, input rxEnable, input txEnable);
endinterface

// ==== rtl/plmc_pause_resolve.sv ====
/*
 * Standard pause resolution from local and partner capabilities.
 * Assumes the caller gates the result with full duplex and latches it.
 */
`timescale 1ns/1ps
module plmc_pause_resolve (
    plmc_pause_if.resolver pauseBus
);
    logic lp;
    logic la;
    logic pp;
    logic pa;

    // Both ends symmetric gives both directions; asymmetric pairs give one direction each.
    assign lp = pauseBus.localCaps.symPause;
    assign la = pauseBus.localCaps.asymDir;
    assign pp = pauseBus.partnerCaps.symPause;
    assign pa = pauseBus.partnerCaps.asymDir;
    assign pauseBus.rxEnable = (lp & pp) | (lp & la & ~pp & pa);
    assign pauseBus.txEnable = (lp & pp) | (~lp & la & pp & pa);
endmodule

// ==== rtl/plmc_regs.sv ====
/*
 * APB register group for the receive buffer tolerance, LED direct control and upper PHY control bits.
 * Assumes the negotiation engine, crossover detector and link status come from logic on clk_sys;
 * the crossover strap is a pin and is synchronised here.
 */
`timescale 1ns/1ps
`include "plmc_cfg.svh"
module plmc_regs (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        strapAutoCrossover,
    input  wire logic        negotiationEnable,
    input  wire logic        negotiationStart,
    input  wire logic        negotiationComplete,
    input  wire logic        fullDuplex,
    input  wire logic        linkUp,
    input  wire logic [15:0] localAdvertisement,
    input  wire logic [15:0] partnerAbility,
    input  wire logic        autoCrossoverSelect,
    output logic             linkIndicatorPin,
    output logic             crossPairs,
    output logic             autoCrossoverActive,
    output logic [1:0]       rxElasticityTolerance,
    output logic [3:0]       rxToleranceBits,
    output logic [14:0]      rxMaxPacketBytes,
    output logic             selftestErrorInject
);

    ////////////////////////////////////////////////////////////////////////////////////////
    // Bus decode.

    logic [5:0]  wordIdx;
    logic        setupPhase;
    logic        writeAccess;
    logic        hitRxBuf;
    logic        hitLedCtl;
    logic        hitPhyCtl;
    logic        mapped;
    logic        wrRxBuf;
    logic        wrLedCtl;
    logic        wrPhyCtl;

    // Registers are one aligned word each; the low address bits are ignored.
    assign wordIdx     = paddr[7:2];
    assign setupPhase  = psel & ~penable;
    assign writeAccess = psel & penable & pwrite;
    assign hitRxBuf    = (wordIdx == `PLMC_IDX_RX_BUF);
    assign hitLedCtl   = (wordIdx == `PLMC_IDX_LED_CTL);
    assign hitPhyCtl   = (wordIdx == `PLMC_IDX_PHY_CTL);
    assign mapped      = hitRxBuf | hitLedCtl | hitPhyCtl;
    assign wrRxBuf     = writeAccess & hitRxBuf;
    assign wrLedCtl    = writeAccess & hitLedCtl;
    assign wrPhyCtl    = writeAccess & hitPhyCtl;

    // Zero wait states: every access phase completes, unmapped words answer with an error.
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Strap synchroniser and capture.

    logic strapMeta_r;
    logic strapSync_r;
    logic strapTaken_r;

    // The strap is a pin, so it passes two flops before anything looks at it.
    always_ff @(posedge clk_sys) begin
        strapMeta_r <= strapAutoCrossover;
        strapSync_r <= strapMeta_r;
    end

    // Marks the first cycle after reset release, when the strap is loaded.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            strapTaken_r <= 1'b0;
        end else begin
            strapTaken_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Receive buffer configuration.

    plmc_pkg::plmc_tol_t rxTol_r;
    logic                wideAccuracy_r;

    // Tolerance field in the low lane, wide-accuracy flag in the second lane.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rxTol_r        <= plmc_pkg::plmc_tol_t'(`PLMC_RXB_TOL_RST);
            wideAccuracy_r <= 1'b0;
        end else if (wrRxBuf) begin
            if (pstrb[0]) begin
                rxTol_r <= plmc_pkg::plmc_tol_t'(pwdata[`PLMC_RXB_TOL_LSB +: 2]);
            end
            if (pstrb[1]) begin
                wideAccuracy_r <= pwdata[`PLMC_RXB_WIDE_BIT];
            end
        end
    end

    // Decoded limits are registered so the buffer sees steady values.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rxToleranceBits  <= `PLMC_TOL_BITS_01;
            rxMaxPacketBytes <= `PLMC_PKT_BYTES_01;
        end else begin
            unique case (rxTol_r)
                plmc_pkg::PLMC_TOL_14: begin
                    rxToleranceBits  <= `PLMC_TOL_BITS_00;
                    rxMaxPacketBytes <= wideAccuracy_r ? (`PLMC_PKT_BYTES_00 >> 1) : `PLMC_PKT_BYTES_00;
                end
                plmc_pkg::PLMC_TOL_2: begin
                    rxToleranceBits  <= `PLMC_TOL_BITS_01;
                    rxMaxPacketBytes <= wideAccuracy_r ? (`PLMC_PKT_BYTES_01 >> 1) : `PLMC_PKT_BYTES_01;
                end
                plmc_pkg::PLMC_TOL_6: begin
                    rxToleranceBits  <= `PLMC_TOL_BITS_10;
                    rxMaxPacketBytes <= wideAccuracy_r ? (`PLMC_PKT_BYTES_10 >> 1) : `PLMC_PKT_BYTES_10;
                end
                plmc_pkg::PLMC_TOL_10: begin
                    rxToleranceBits  <= `PLMC_TOL_BITS_11;
                    rxMaxPacketBytes <= wideAccuracy_r ? (`PLMC_PKT_BYTES_11 >> 1) : `PLMC_PKT_BYTES_11;
                end
            endcase
        end
    end

    // The halving of the limit is what the wide-accuracy flag buys.
    assign rxElasticityTolerance = rxTol_r;

    ////////////////////////////////////////////////////////////////////////////////////////
    // LED direct control.

    logic ledOverride_r;
    logic ledForced_r;

    // Only the two defined bits are stored; reserved bits have no flops at all.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ledOverride_r <= 1'b0;
            ledForced_r   <= 1'b0;
        end else if (wrLedCtl && pstrb[0]) begin
            ledOverride_r <= pwdata[`PLMC_LED_OVR_BIT];
            ledForced_r   <= pwdata[`PLMC_LED_FORCE_BIT];
        end
    end

    // Override selects the forced value; otherwise the LED shows good link.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            linkIndicatorPin <= 1'b0;
        end else begin
            linkIndicatorPin <= ledOverride_r ? ledForced_r : linkUp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Crossover control.

    logic autoCrossEn_r;
    logic forceCross_r;

    // The strap loads once after release; a bus write in that same cycle still wins.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            autoCrossEn_r <= 1'b0;
        end else if (wrPhyCtl && pstrb[1]) begin
            autoCrossEn_r <= pwdata[`PLMC_PHY_AUTOX_BIT];
        end else if (!strapTaken_r) begin
            autoCrossEn_r <= strapSync_r;
        end
    end

    // Force bit is an ordinary read-write flag.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            forceCross_r <= 1'b0;
        end else if (wrPhyCtl && pstrb[1]) begin
            forceCross_r <= pwdata[`PLMC_PHY_FORCEX_BIT];
        end
    end

    // Detection only steers the pairs while negotiation runs; forcing overrides it.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            autoCrossoverActive <= 1'b0;
            crossPairs          <= 1'b0;
        end else begin
            autoCrossoverActive <= autoCrossEn_r & negotiationEnable;
            crossPairs          <= forceCross_r | (autoCrossEn_r & negotiationEnable & autoCrossoverSelect);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Pause resolution.

    plmc_pause_if pauseBus ();
    logic         pauseRx_r;
    logic         pauseTx_r;

    assign pauseBus.localCaps   = localAdvertisement[`PLMC_ADV_PAUSE_LSB +: 2];
    assign pauseBus.partnerCaps = partnerAbility[`PLMC_ADV_PAUSE_LSB +: 2];

    plmc_pause_resolve uResolve (
        .pauseBus (pauseBus.resolver)
    );

    // Results load at negotiation end; a restart or link loss clears them and wins.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pauseRx_r <= 1'b0;
            pauseTx_r <= 1'b0;
        end else if (negotiationStart || !linkUp) begin
            pauseRx_r <= 1'b0;
            pauseTx_r <= 1'b0;
        end else if (negotiationComplete) begin
            pauseRx_r <= pauseBus.rxEnable & fullDuplex;
            pauseTx_r <= pauseBus.txEnable & fullDuplex;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Self-test error injection.

    // A write of one raises the bit for exactly one cycle, which is the injected error.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            selftestErrorInject <= 1'b0;
        end else begin
            selftestErrorInject <= wrPhyCtl & pstrb[1] & pwdata[`PLMC_PHY_INJ_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Read data.

    logic [31:0] readWord;

    // LED reads return the stored bits, never the pin, and zeros elsewhere.
    always_comb begin
        readWord = 32'h0000_0000;
        if (hitRxBuf) begin
            readWord[`PLMC_RXB_TOL_LSB +: 2] = rxTol_r;
            readWord[`PLMC_RXB_WIDE_BIT]     = wideAccuracy_r;
        end else if (hitLedCtl) begin
            readWord[`PLMC_LED_OVR_BIT]   = ledOverride_r;
            readWord[`PLMC_LED_FORCE_BIT] = ledForced_r;
        end else if (hitPhyCtl) begin
            readWord[`PLMC_PHY_AUTOX_BIT]  = autoCrossEn_r;
            readWord[`PLMC_PHY_FORCEX_BIT] = forceCross_r;
            readWord[`PLMC_PHY_PRX_BIT]    = pauseRx_r;
            readWord[`PLMC_PHY_PTX_BIT]    = pauseTx_r;
            readWord[`PLMC_PHY_INJ_BIT]    = selftestErrorInject;
        end
    end

    // Read data is captured in the setup cycle so it stands steady through the access phase.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (setupPhase) begin
            prdata <= pwrite ? 32'h0000_0000 : readWord;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    AST_TOL_RESET: assert property ($past(reset) |-> rxTol_r == plmc_pkg::PLMC_TOL_2)
        else $error("Tolerance field did not reset to one.");

    AST_TOL_MAP: assert property ((rxTol_r == plmc_pkg::PLMC_TOL_14) ##1 (rxTol_r == plmc_pkg::PLMC_TOL_14)
        |-> rxToleranceBits == 4'hE)
        else $error("Code zero did not give fourteen bits.");

    AST_PKT_HALF: assert property ((rxTol_r == plmc_pkg::PLMC_TOL_2) && wideAccuracy_r
        ##1 (rxTol_r == plmc_pkg::PLMC_TOL_2) && wideAccuracy_r |-> rxMaxPacketBytes == 15'h04B0)
        else $error("Wide accuracy did not halve the packet limit.");

    AST_LED_FORCE: assert property (ledOverride_r |=> linkIndicatorPin == $past(ledForced_r))
        else $error("LED did not follow the forced value.");

    AST_LED_NORMAL: assert property (!ledOverride_r |=> linkIndicatorPin == $past(linkUp))
        else $error("LED did not follow link status.");

    AST_LED_READ: assert property (setupPhase && !pwrite && hitLedCtl |=>
        prdata[31:5] == 27'h0 && prdata[3:2] == 2'h0 && !prdata[0] && prdata[1] == $past(ledForced_r))
        else $error("LED register read returned more than its stored bits.");

    AST_STRAP_LOAD: assert property (!strapTaken_r && !(wrPhyCtl && pstrb[1]) |=> autoCrossEn_r == $past(strapSync_r))
        else $error("Crossover enable did not load from the strap.");

    AST_FORCE_CROSS: assert property (forceCross_r |=> crossPairs)
        else $error("Forced crossover did not cross the pairs.");

    AST_AUTO_GATE: assert property (!forceCross_r && !negotiationEnable |=> !crossPairs)
        else $error("Pairs crossed without negotiation enabled.");

    AST_PAUSE_DUPLEX: assert property ($rose(pauseRx_r) || $rose(pauseTx_r) |-> $past(fullDuplex))
        else $error("Pause result raised without full duplex.");

    AST_PAUSE_CLEAR: assert property (negotiationStart || !linkUp |=> !pauseRx_r && !pauseTx_r)
        else $error("Pause results not cleared on restart or link loss.");

    AST_PAUSE_BOTH: assert property (negotiationComplete && fullDuplex && linkUp && !negotiationStart
        && localAdvertisement[10] && partnerAbility[10] |=> pauseRx_r && pauseTx_r)
        else $error("Symmetric pause did not enable both directions.");

    AST_INJ_WRITE: assert property (wrPhyCtl && pstrb[1] && pwdata[11] |=> selftestErrorInject)
        else $error("Write of one did not inject an error.");

    AST_INJ_ONCE: assert property (selftestErrorInject && !$past(selftestErrorInject) && !(wrPhyCtl && pstrb[1] && pwdata[11])
        |=> !selftestErrorInject)
        else $error("Injection bit did not clear itself.");

endmodule

// ==== tb/tb_top.sv ====
/*
 * Self-checking bench for the LED, crossover, pause and receive tolerance register group.
 * Assumes the group answers APB with zero wait states and that its assertions live in its own files.
 */
`timescale 1ns/1ps
`include "plmc_cfg.svh"
module tb_top;

    localparam logic [7:0] ADDR_RXB = {`PLMC_IDX_RX_BUF, 2'h0};
    localparam logic [7:0] ADDR_LED = {`PLMC_IDX_LED_CTL, 2'h0};
    localparam logic [7:0] ADDR_PHY = {`PLMC_IDX_PHY_CTL, 2'h0};

    logic        clk_sys;
    logic        reset;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        strapAutoCrossover;
    logic        negotiationEnable;
    logic        negotiationStart;
    logic        negotiationComplete;
    logic        fullDuplex;
    logic        linkUp;
    logic [15:0] localAdvertisement;
    logic [15:0] partnerAbility;
    logic        autoCrossoverSelect;
    logic        linkIndicatorPin;
    logic        crossPairs;
    logic        autoCrossoverActive;
    logic [1:0]  rxElasticityTolerance;
    logic [3:0]  rxToleranceBits;
    logic [14:0] rxMaxPacketBytes;
    logic        selftestErrorInject;
    int          mismatches;
    int          checked;
    int          cycles;

    plmc_regs u_plmc_regs (
        .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .strapAutoCrossover(strapAutoCrossover),
        .negotiationEnable(negotiationEnable), .negotiationStart(negotiationStart),
        .negotiationComplete(negotiationComplete), .fullDuplex(fullDuplex), .linkUp(linkUp),
        .localAdvertisement(localAdvertisement), .partnerAbility(partnerAbility),
        .autoCrossoverSelect(autoCrossoverSelect), .linkIndicatorPin(linkIndicatorPin),
        .crossPairs(crossPairs), .autoCrossoverActive(autoCrossoverActive),
        .rxElasticityTolerance(rxElasticityTolerance), .rxToleranceBits(rxToleranceBits),
        .rxMaxPacketBytes(rxMaxPacketBytes), .selftestErrorInject(selftestErrorInject)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Clock generation and a cycle ceiling, so a stuck handshake cannot hang the run.
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches = mismatches + 1;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared comparison, bus cycle and settling helpers.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // The request is held until pready is sampled high; read data is taken at that same edge.
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        // Only the bench's cycle ceiling ends a wait that never sees pready.
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
        logic [31:0] d;
        logic        e;
        apb(1'b1, addr, wd, d, e);
    endtask

    task automatic rd(input logic [7:0] addr, output logic [31:0] d);
        logic e;
        apb(1'b0, addr, 32'h0, d, e);
        check(e, 32'h0);
        check(pready, 32'h1);
    endtask

    // Two edges let registered outputs land; the small delay keeps sampling off the edge.
    task automatic settle();
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    task automatic report_and_stop();
        if (mismatches == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic test_reset_values();
        logic [31:0] d;
        check(rxElasticityTolerance, 32'h1);
        check(rxToleranceBits, 32'h2);
        check(rxMaxPacketBytes, 32'h960);
        rd(ADDR_RXB, d);
        check(d, 32'h1);
        rd(ADDR_LED, d);
        check(d, 32'h0);
        rd(ADDR_PHY, d);
        check(d, 32'h8000);
    endtask

    task automatic test_tolerance();
        logic [3:0]  expBits [4] = '{4'hE, 4'h2, 4'h6, 4'hA};
        logic [14:0] expBytes[4] = '{15'h41A0, 15'h0960, 15'h1C20, 15'h2EE0};
        logic [31:0] d;
        logic [31:0] v;
        for (int c = 0; c < 4; c++) begin
            for (int w = 0; w < 2; w++) begin
                v = {23'h000000, w[0], 6'h00, c[1:0]};
                wr(ADDR_RXB, v);
                settle();
                check(rxElasticityTolerance, c[1:0]);
                check(rxToleranceBits, expBits[c]);
                check(rxMaxPacketBytes, expBytes[c] >> w);
                rd(ADDR_RXB, d);
                check(d, v);
            end
        end
        wr(ADDR_RXB, 32'h1);
    endtask

    task automatic test_led();
        logic [31:0] d;
        linkUp <= 1'b1;
        wr(ADDR_LED, 32'hFFFFFFD2);
        rd(ADDR_LED, d);
        check(d, 32'h12);
        wr(ADDR_LED, 32'h10);
        settle();
        check(linkIndicatorPin, 32'h0);
        wr(ADDR_LED, 32'h0);
        settle();
        check(linkIndicatorPin, 32'h1);
        rd(ADDR_LED, d);
        check(d, 32'h0);
        linkUp <= 1'b0;
        wr(ADDR_LED, 32'h12);
        settle();
        check(linkIndicatorPin, 32'h1);
        wr(ADDR_LED, 32'h0);
        settle();
        check(linkIndicatorPin, 32'h0);
        @(posedge clk_sys);
        linkUp <= 1'b1;
    endtask

    task automatic test_crossover();
        logic [31:0] d;
        autoCrossoverSelect <= 1'b1;
        settle();
        check(autoCrossoverActive, 32'h1);
        check(crossPairs, 32'h1);
        @(posedge clk_sys);
        negotiationEnable <= 1'b0;
        settle();
        check(autoCrossoverActive, 32'h0);
        check(crossPairs, 32'h0);
        // Software clears the crossover enable while negotiation is off.
        wr(ADDR_PHY, 32'h0);
        negotiationEnable <= 1'b1;
        settle();
        check(crossPairs, 32'h0);
        @(posedge clk_sys);
        autoCrossoverSelect <= 1'b0;
        wr(ADDR_PHY, 32'h4000);
        settle();
        check(crossPairs, 32'h1);
        rd(ADDR_PHY, d);
        check(d, 32'h4000);
        wr(ADDR_PHY, 32'h0);
    endtask

    task automatic test_inject();
        logic [31:0] d;
        wr(ADDR_PHY, 32'h800);
        #1;
        check(selftestErrorInject, 32'h1);
        @(posedge clk_sys);
        #1;
        check(selftestErrorInject, 32'h0);
        rd(ADDR_PHY, d);
        check(d, 32'h0);
        wr(ADDR_PHY, 32'h0);
        #1;
        check(selftestErrorInject, 32'h0);
    endtask

    // Every capability pairing is tried with and without full duplex.
    task automatic test_pause();
        logic [31:0] d;
        logic [4:0]  c;
        logic        er;
        logic        et;
        for (int i = 0; i < 32; i++) begin
            c = i[4:0];
            @(posedge clk_sys);
            localAdvertisement  <= {4'h0, c[1], c[0], 10'h000};
            partnerAbility      <= {4'h0, c[3], c[2], 10'h000};
            fullDuplex          <= c[4];
            negotiationComplete <= 1'b1;
            @(posedge clk_sys);
            negotiationComplete <= 1'b0;
            er = (c[0] & c[2]) | (c[0] & c[1] & ~c[2] & c[3]);
            et = (c[0] & c[2]) | (~c[0] & c[1] & c[2] & c[3]);
            rd(ADDR_PHY, d);
            check(d[13], er & c[4]);
            check(d[12], et & c[4]);
        end
        @(posedge clk_sys);
        negotiationStart <= 1'b1;
        @(posedge clk_sys);
        negotiationStart <= 1'b0;
        rd(ADDR_PHY, d);
        check(d, 32'h0);
        negotiationComplete <= 1'b1;
        @(posedge clk_sys);
        negotiationComplete <= 1'b0;
        rd(ADDR_PHY, d);
        check(d, 32'h3000);
        linkUp <= 1'b0;
        rd(ADDR_PHY, d);
        check(d, 32'h0);
        linkUp <= 1'b1;
    endtask

    task automatic test_unmapped();
        logic [31:0] d;
        logic        e;
        // A write with no lane strobes must leave the field untouched.
        pstrb <= 4'h0;
        wr(ADDR_RXB, 32'h2);
        pstrb <= 4'hF;
        rd(ADDR_RXB, d);
        check(d, 32'h1);
        apb(1'b1, 8'h00, 32'hFFFFFFFF, d, e);
        check(e, 32'h1);
        apb(1'b0, 8'h00, 32'h0, d, e);
        check(e, 32'h1);
        check(d, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence; the strap is held high so crossover enable must load as one.
    initial begin
        mismatches = 0;
        checked = 0;
        cycles = 0;
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
        strapAutoCrossover = 1'b1;
        negotiationEnable = 1'b1;
        negotiationStart = 1'b0;
        negotiationComplete = 1'b0;
        fullDuplex = 1'b0;
        linkUp = 1'b1;
        localAdvertisement = 16'h0000;
        partnerAbility = 16'h0000;
        autoCrossoverSelect = 1'b0;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        settle();
        test_reset_values();
        test_crossover();
        test_tolerance();
        test_led();
        test_inject();
        test_pause();
        test_unmapped();
        report_and_stop();
    end

endmodule
